// ---- addr_filter_pkg.sv ----
// Purpose: Shared constants for the compatibility-mode address filter
// Assumes: 25 MHz system clock, classic Wishbone register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
`default_nettype none
package addr_filter_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_DEST_ADDR = 8'h04;
  localparam logic [7:0] REG_OWN_ADDR  = 8'h08;
  localparam logic [7:0] REG_TX_DELAY  = 8'h0C;
  localparam logic [7:0] REG_EOM_PAUSE = 8'h10;
  localparam logic [7:0] REG_CMD       = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_COUNT     = 8'h1C;
  // Control field positions
  localparam int CTRL_TX_ADDR_EN = 0;
  localparam int CTRL_RX_ADDR_EN = 1;
  localparam int CTRL_FEC_EN     = 2;
  localparam int CTRL_PRIO_TX    = 3;
  localparam int CTRL_MODE_LSB   = 8;
  localparam int CTRL_MODE_W     = 5;
  // Status field positions
  localparam int STAT_REPEATER   = 0;
  localparam int STAT_FEC_ACT    = 1;
  localparam int STAT_CSMA       = 2;
  localparam int STAT_TX_BUSY    = 3;
  localparam int STAT_ADDR_USE   = 4;
  // Commands written to the command register
  localparam logic [7:0] CMD_REPEATER_ON  = 8'h01;
  localparam logic [7:0] CMD_REPEATER_OFF = 8'h02;
  localparam logic [7:0] CMD_COMPAT_OPT3  = 8'h03;
  // Reset values
  localparam logic [15:0] DEST_ADDR_RST = 16'h00FF;
  localparam logic [15:0] OWN_ADDR_RST  = 16'h0000;
  localparam logic [7:0]  BROADCAST     = 8'hFF;
  localparam logic [4:0]  MODE_NATIVE   = 5'h00;
  localparam logic [4:0]  MODE_OPT3     = 5'h03;
  localparam logic [15:0] TX_DELAY_RST  = 16'h0000;
  localparam logic [15:0] TX_DELAY_MAX  = 16'hFDE8;
  localparam logic [15:0] TX_DELAY_LOCK = 16'h0032;
  localparam logic [15:0] TX_DELAY_LAT  = 16'h0022;
  localparam logic [7:0]  EOM_PAUSE_RST = 8'h03;
  // Timing
  localparam int CLK_HZ        = 25000000;
  localparam int MS_CYCLES     = CLK_HZ / 1000;
  localparam int BYTE_TIME_NS  = 1042;
  localparam int BYTE_CYCLES   = (BYTE_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
endpackage
`default_nettype wire

// ---- compat_mode_address_filter.sv ----
// Purpose: Address labelling and filtering for compatibility radio modes
// Assumes: Host bytes arrive on a same-clock stream; peer frames already decoded
// Notes:   Wishbone classic slave, one wait state, ack for one cycle
`default_nettype none
module compat_mode_address_filter
  import addr_filter_pkg::*;
#(
  parameter int MS_CNT = addr_filter_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  // Host serial bytes in
  input  wire logic        i_host_valid,
  input  wire logic [7:0]  i_host_data,
  output logic             o_host_ready,
  // Frame bytes to modulator, bit 8 marks last byte
  output logic [8:0]       o_tx_data,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output logic [7:0]       o_tx_dest,
  // Received frame header from demodulator
  input  wire logic        i_rx_hdr_valid,
  input  wire logic [7:0]  i_rx_hdr_dest,
  output logic             o_rx_accept,
  output logic             o_rx_drop,
  // Mode outputs
  output logic             o_fec_active,
  output logic             o_repeater_en,
  output logic             o_csma_en
);
  typedef enum logic [1:0] {ST_COLLECT, ST_DELAY, ST_SEND} tx_state_t;

  // Configuration registers
  logic [15:0] dest_addr_ff;
  logic [15:0] own_addr_ff;
  logic [15:0] tx_delay_ff;
  logic [7:0]  eom_pause_ff;
  logic        tx_addr_en_ff;
  logic        rx_addr_en_ff;
  logic        fec_en_ff;
  logic        prio_tx_ff;
  logic [4:0]  mode_ff;
  logic        repeater_ff;
  logic [15:0] acc_cnt_ff;
  logic [15:0] drop_cnt_ff;
  // Transfer engine
  tx_state_t   state_ff;
  logic [15:0] gap_cnt_ff;
  logic [7:0]  gap_bytes_ff;
  logic [15:0] ms_sub_ff;
  logic [15:0] ms_left_ff;
  logic [8:0]  msg_mem [256];
  logic [7:0]  wr_ptr_ff;
  logic [7:0]  rd_ptr_ff;
  logic        have_data_ff;
  logic        rx_accept_ff;
  logic        rx_drop_ff;
  logic [31:0] rd_data;
  logic        wb_req;
  logic        wr_ctrl;
  logic        addr_off;
  logic        gap_done;
  logic        byte_tick;
  frame_buf_if fb ();

  // Low byte compare, 255 in either address means broadcast
  function automatic logic addr_match(input logic [15:0] a, input logic [7:0] b);
    addr_match = (a[7:0] == b) || (a[7:0] == BROADCAST) || (b == BROADCAST);
  endfunction

  assign wb_req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_ctrl  = wb_req && i_wb_we && i_wb_sel[0];
  assign addr_off = (mode_ff == MODE_OPT3);

  // Single wait state ack, dropped the cycle after
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_data : 32'h00000000;
    end
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    rd_data = 32'h00000000;
    case (i_wb_adr)
      REG_CTRL: begin
        rd_data[CTRL_TX_ADDR_EN] = tx_addr_en_ff;
        rd_data[CTRL_RX_ADDR_EN] = rx_addr_en_ff;
        rd_data[CTRL_FEC_EN]     = fec_en_ff;
        rd_data[CTRL_PRIO_TX]    = prio_tx_ff;
        rd_data[CTRL_MODE_LSB +: CTRL_MODE_W] = mode_ff;
      end
      REG_DEST_ADDR: rd_data[15:0] = dest_addr_ff;
      REG_OWN_ADDR:  rd_data[15:0] = own_addr_ff;
      REG_TX_DELAY:  rd_data[15:0] = tx_delay_ff;
      REG_EOM_PAUSE: rd_data[7:0]  = eom_pause_ff;
      REG_STATUS: begin
        rd_data[STAT_REPEATER] = repeater_ff;
        rd_data[STAT_FEC_ACT]  = o_fec_active;
        rd_data[STAT_CSMA]     = o_csma_en;
        rd_data[STAT_TX_BUSY]  = (state_ff != ST_COLLECT);
        rd_data[STAT_ADDR_USE] = !addr_off;
      end
      REG_COUNT: rd_data = {drop_cnt_ff, acc_cnt_ff};
      default: rd_data = 32'h00000000;
    endcase
  end

  // Address and timing registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dest_addr_ff <= DEST_ADDR_RST;
      own_addr_ff  <= OWN_ADDR_RST;
      tx_delay_ff  <= TX_DELAY_RST;
      eom_pause_ff <= EOM_PAUSE_RST;
    end else if (wb_req && i_wb_we) begin
      case (i_wb_adr)
        REG_DEST_ADDR: begin
          if (i_wb_sel[0]) dest_addr_ff[7:0]  <= i_wb_dat[7:0];
          if (i_wb_sel[1]) dest_addr_ff[15:8] <= i_wb_dat[15:8];
        end
        REG_OWN_ADDR: begin
          if (i_wb_sel[0]) own_addr_ff[7:0]  <= i_wb_dat[7:0];
          if (i_wb_sel[1]) own_addr_ff[15:8] <= i_wb_dat[15:8];
        end
        REG_TX_DELAY: begin
          // Clamp oversize writes to the top of the range
          if (i_wb_sel[1:0] == 2'b11) begin
            tx_delay_ff <= (i_wb_dat[15:0] > TX_DELAY_MAX) ? TX_DELAY_MAX
                                                           : i_wb_dat[15:0];
          end
        end
        REG_EOM_PAUSE: if (i_wb_sel[0]) eom_pause_ff <= i_wb_dat[7:0];
        default: ;
      endcase
    end
  end

  // Control bits and commands
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tx_addr_en_ff <= 1'b0;
      rx_addr_en_ff <= 1'b0;
      fec_en_ff     <= 1'b0;
      prio_tx_ff    <= 1'b0;
      mode_ff       <= MODE_NATIVE;
      repeater_ff   <= 1'b0;
    end else if (wr_ctrl && i_wb_adr == REG_CTRL) begin
      tx_addr_en_ff <= i_wb_dat[CTRL_TX_ADDR_EN];
      rx_addr_en_ff <= i_wb_dat[CTRL_RX_ADDR_EN];
      fec_en_ff     <= i_wb_dat[CTRL_FEC_EN];
      prio_tx_ff    <= i_wb_dat[CTRL_PRIO_TX];
      if (i_wb_sel[1]) mode_ff <= i_wb_dat[CTRL_MODE_LSB +: CTRL_MODE_W];
    end else if (wr_ctrl && i_wb_adr == REG_CMD) begin
      case (i_wb_dat[7:0])
        CMD_REPEATER_ON:  repeater_ff <= 1'b1;
        CMD_REPEATER_OFF: repeater_ff <= 1'b0;
        CMD_COMPAT_OPT3: begin
          // Addressing is meaningless here, so drop both enables
          mode_ff       <= MODE_OPT3;
          tx_addr_en_ff <= 1'b0;
          rx_addr_en_ff <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // FEC stored setting is kept, only its effect is gated per mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_fec_active  <= 1'b0;
      o_repeater_en <= 1'b0;
      o_csma_en     <= 1'b1;
    end else begin
      o_fec_active  <= fec_en_ff && (mode_ff == MODE_NATIVE);
      o_repeater_en <= repeater_ff;
      o_csma_en     <= !prio_tx_ff;
    end
  end

  // Receive filter, peer frames are labelled not acknowledged
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rx_accept_ff <= 1'b0;
      rx_drop_ff   <= 1'b0;
      acc_cnt_ff   <= 16'h0000;
      drop_cnt_ff  <= 16'h0000;
    end else begin
      rx_accept_ff <= 1'b0;
      rx_drop_ff   <= 1'b0;
      if (i_rx_hdr_valid) begin
        if (addr_off || !rx_addr_en_ff || addr_match(own_addr_ff, i_rx_hdr_dest)) begin
          rx_accept_ff <= 1'b1;
          acc_cnt_ff   <= 16'(acc_cnt_ff + 16'h0001);
        end else begin
          rx_drop_ff   <= 1'b1;
          drop_cnt_ff  <= 16'(drop_cnt_ff + 16'h0001);
        end
      end
    end
  end
  assign o_rx_accept = rx_accept_ff;
  assign o_rx_drop   = rx_drop_ff;

  // Destination label, broadcast when addressing is off
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_tx_dest <= BROADCAST;
    end else begin
      o_tx_dest <= (tx_addr_en_ff && !addr_off) ? dest_addr_ff[7:0] : BROADCAST;
    end
  end

  // Byte-interval tick for gap measurement
  assign byte_tick = (gap_cnt_ff == 16'(BYTE_CYCLES - 1));
  assign gap_done  = have_data_ff && (gap_bytes_ff >= eom_pause_ff);

  // Gap timer restarts on every host byte
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || (i_host_valid && o_host_ready) || state_ff != ST_COLLECT) begin
      gap_cnt_ff   <= 16'h0000;
      gap_bytes_ff <= 8'h00;
    end else if (byte_tick) begin
      gap_cnt_ff   <= 16'h0000;
      if (gap_bytes_ff != 8'hFF) gap_bytes_ff <= 8'(gap_bytes_ff + 8'h01);
    end else begin
      gap_cnt_ff   <= 16'(gap_cnt_ff + 16'h0001);
    end
  end

  // Message store, bytes kept with bit 8 clear; end marker is added on read
  always_ff @(posedge i_clk_sys) begin
    if (i_host_valid && o_host_ready) begin
      msg_mem[wr_ptr_ff] <= {1'b0, i_host_data};
    end
  end

  // Collect, wait out the delay, then send
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_ff     <= ST_COLLECT;
      wr_ptr_ff    <= 8'h00;
      rd_ptr_ff    <= 8'h00;
      have_data_ff <= 1'b0;
      ms_sub_ff    <= 16'h0000;
      ms_left_ff   <= 16'h0000;
      o_host_ready <= 1'b0;
    end else begin
      case (state_ff)
        ST_COLLECT: begin
          o_host_ready <= (wr_ptr_ff != 8'hFF) && !gap_done;
          if (i_host_valid && o_host_ready) begin
            wr_ptr_ff    <= 8'(wr_ptr_ff + 8'h01);
            have_data_ff <= 1'b1;
          end else if (gap_done || wr_ptr_ff == 8'hFF) begin
            o_host_ready <= 1'b0;
            ms_sub_ff    <= 16'h0000;
            ms_left_ff   <= tx_delay_ff;
            state_ff     <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          // Zero delay passes straight through
          if (ms_left_ff == 16'h0000) begin
            rd_ptr_ff <= 8'h00;
            state_ff  <= ST_SEND;
          end else if (ms_sub_ff == 16'(MS_CNT - 1)) begin
            ms_sub_ff  <= 16'h0000;
            ms_left_ff <= 16'(ms_left_ff - 16'h0001);
          end else begin
            ms_sub_ff  <= 16'(ms_sub_ff + 16'h0001);
          end
        end
        ST_SEND: begin
          // Single pass, nothing kept for resend
          if (fb.ready && rd_ptr_ff == 8'(wr_ptr_ff - 8'h01)) begin
            wr_ptr_ff    <= 8'h00;
            have_data_ff <= 1'b0;
            state_ff     <= ST_COLLECT;
          end else if (fb.ready) begin
            rd_ptr_ff <= 8'(rd_ptr_ff + 8'h01);
          end
        end
        default: state_ff <= ST_COLLECT;
      endcase
    end
  end

  // Stream into the buffer, end marker on last byte
  assign fb.valid = (state_ff == ST_SEND);
  assign fb.data  = {rd_ptr_ff == 8'(wr_ptr_ff - 8'h01), msg_mem[rd_ptr_ff][7:0]};

  skid_buf2 u_buf (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .up        (fb),
    .o_data    (o_tx_data),
    .o_valid   (o_tx_valid),
    .i_ready   (i_tx_ready)
  );

  // Assertions
  property p_rx_exclusive;
    @(posedge i_clk_sys) disable iff (!i_rst_n) !(o_rx_accept && o_rx_drop);
  endproperty
  a_rx_exclusive: assert property (p_rx_exclusive) else $error("accept and drop together");
  property p_bcast_accept;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_rx_hdr_valid && i_rx_hdr_dest == BROADCAST) |=> o_rx_accept;
  endproperty
  a_bcast_accept: assert property (p_bcast_accept) else $error("broadcast dropped");
  property p_mismatch_drop;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_rx_hdr_valid && rx_addr_en_ff && !addr_off && i_rx_hdr_dest != own_addr_ff[7:0]
       && i_rx_hdr_dest != BROADCAST && own_addr_ff[7:0] != BROADCAST) |=> o_rx_drop;
  endproperty
  a_mismatch_drop: assert property (p_mismatch_drop) else $error("foreign frame taken");
  property p_opt3_noaddr;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      addr_off |-> ##2 (o_tx_dest == BROADCAST) || !$past(addr_off);
  endproperty
  a_opt3_noaddr: assert property (p_opt3_noaddr) else $error("address used in option 3");
  property p_fec_opt3;
    @(posedge i_clk_sys) disable iff (!i_rst_n) addr_off |=> !o_fec_active;
  endproperty
  a_fec_opt3: assert property (p_fec_opt3) else $error("fec active in option 3");
  property p_csma;
    @(posedge i_clk_sys) disable iff (!i_rst_n) $rose(prio_tx_ff) |=> !o_csma_en;
  endproperty
  a_csma: assert property (p_csma) else $error("csma not off");
  property p_rep_on;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (wr_ctrl && i_wb_adr == REG_CMD && i_wb_dat[7:0] == CMD_REPEATER_ON) |=> ##1 o_repeater_en;
  endproperty
  a_rep_on: assert property (p_rep_on) else $error("repeater not on");
  // Collection only ends on a pause or a full store
  property p_no_send_early;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_ff == ST_COLLECT && !gap_done && wr_ptr_ff != 8'hFF)
      |=> (state_ff == ST_COLLECT);
  endproperty
  a_no_send_early: assert property (p_no_send_early) else $error("sent before gap");
  property p_ack_pulse;
    @(posedge i_clk_sys) disable iff (!i_rst_n) o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  c_accept: cover property (@(posedge i_clk_sys) o_rx_accept);
  c_drop:   cover property (@(posedge i_clk_sys) o_rx_drop);
  c_send:   cover property (@(posedge i_clk_sys) o_tx_valid && o_tx_data[8]);
endmodule
`default_nettype wire

// ---- frame_buf_if.sv ----
// Purpose: Valid/ready carrier for bytes between filter and buffer
// Assumes: Single clock domain
// Notes:   Eight data bits plus end-of-message marker
`default_nettype none
interface frame_buf_if;
  logic [8:0] data;
  logic       valid;
  logic       ready;
  modport src  (output data, output valid, input ready);
  modport sink (input data, input valid, output ready);
endinterface
`default_nettype wire

// ---- peer_modem_model.sv ----
// Purpose: Behavioural peer radio across the air side of the filter
// Assumes: Same clock as the filter, frames already decoded
// Notes:   Slow mode takes a byte only every third cycle
`default_nettype none
module peer_modem_model #(
  parameter logic [7:0] LOCAL_ADDR = 8'h00,
  parameter logic [7:0] SEC_CODE   = 8'h00
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // Test control
  input  wire logic       i_slow,
  input  wire logic       i_send,
  input  wire logic [7:0] i_send_dest,
  // Frames from the filter
  input  wire logic [8:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  input  wire logic [7:0] i_tx_dest,
  // Headers towards the filter
  output logic            o_hdr_valid,
  output logic [7:0]      o_hdr_dest,
  // Observed traffic
  output logic [7:0]      o_nbytes,
  output logic [7:0]      o_last_byte,
  output logic [7:0]      o_frame_dest,
  output logic            o_delivered
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pace_ff;

  // Receiver pacing, stalls to exercise the buffer
  // Pacer is reset so the slow mode never starts from an unknown phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pace_ff <= 2'h0;
    end else begin
      pace_ff <= (pace_ff == 2'h2) ? 2'h0 : 2'(pace_ff + 2'h1);
    end
    o_tx_ready <= i_rst_n && (!i_slow || pace_ff == 2'h0);
  end

  // Frame capture; delivery only on local or broadcast label
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_nbytes <= 8'h00;
    end else if (i_tx_valid && o_tx_ready) begin
      o_nbytes <= o_nbytes + 8'h01;
      if (i_tx_data[8]) begin
        o_last_byte  <= i_tx_data[7:0];
        o_frame_dest <= i_tx_dest;
        o_delivered  <= (i_tx_dest == LOCAL_ADDR || i_tx_dest == 8'hFF)
                        && SEC_CODE == 8'h00;
      end
    end
  end

  // Idle header line toggles so a stale value never looks valid
  always_ff @(posedge i_clk_sys) begin
    o_hdr_valid <= i_rst_n && i_send;
    o_hdr_dest  <= i_send ? i_send_dest : ~o_hdr_dest;
  end
endmodule
`default_nettype wire

// ---- skid_buf2.sv ----
// Purpose: Two-entry buffer between frame logic and downstream sink
// Assumes: Same clock for both sides
// Notes:   Ready upstream is registered full flag, so no comb path
`default_nettype none
module skid_buf2 (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Upstream side
  frame_buf_if.sink        up,
  // Downstream side
  output logic [8:0]       o_data,
  output logic             o_valid,
  input  wire logic        i_ready
);
  logic [8:0] mem_ff [2];
  logic       rd_ff;
  logic       wr_ff;
  logic [1:0] cnt_ff;
  logic       push;
  logic       pop;

  // Handshake terms
  assign push    = up.valid && up.ready;
  assign pop     = o_valid && i_ready;
  assign up.ready = (cnt_ff != 2'd2);
  assign o_valid = (cnt_ff != 2'd0);
  assign o_data  = mem_ff[rd_ff];

  // Storage write
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_ff[wr_ff] <= up.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rd_ff  <= 1'b0;
      wr_ff  <= 1'b0;
      cnt_ff <= 2'd0;
    end else begin
      if (push) wr_ff <= ~wr_ff;
      if (pop) rd_ff <= ~rd_ff;
      cnt_ff <= 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule
`default_nettype wire

// ---- tb_compat_mode_address_filter.sv ----
// Purpose: Self-checking bench for the compatibility address filter
// Assumes: Millisecond count shortened to 10 cycles
// Notes:   Filter cases run from a table, odd cases by hand
`default_nettype none
module tb_compat_mode_address_filter;
  timeunit 1ns;
  timeprecision 1ps;
  import addr_filter_pkg::*;
  typedef struct packed {
    logic        rxen;
    logic [15:0] own;
    logic [7:0]  dest;
    logic        acc;
  } rx_case_t;
  // Receive-filter table: enable, own address, header, accept
  rx_case_t rows [6] = '{
    '{1'b0, 16'h0005, 8'h77, 1'b1}, '{1'b1, 16'h0005, 8'h05, 1'b1},
    '{1'b1, 16'h0005, 8'h06, 1'b0}, '{1'b1, 16'h0005, 8'hFF, 1'b1},
    '{1'b1, 16'h0105, 8'h05, 1'b1}, '{1'b1, 16'h00FF, 8'h12, 1'b1}};
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, hv = 0, send = 0, slow = 0;
  logic [7:0]  adr = 8'h00, hd = 8'h00, sdest = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_q;
  wire  [31:0] o_wb_dat;
  wire  [8:0]  tx_data;
  wire  [7:0]  tx_dest, hdr_dest, nbytes, last_b, f_dest;
  wire         ack, host_rdy, tx_valid, tx_rdy, hdr_v, acc, drop, fec, rep, csma, dlv;
  int          fail_count = 0, num_checks = 0;
  logic [7:0]  base;

  compat_mode_address_filter #(.MS_CNT(10)) compat_mode_address_filter_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(ack),
    .i_host_valid(hv), .i_host_data(hd), .o_host_ready(host_rdy), .o_tx_data(tx_data),
    .o_tx_valid(tx_valid), .i_tx_ready(tx_rdy), .o_tx_dest(tx_dest),
    .i_rx_hdr_valid(hdr_v), .i_rx_hdr_dest(hdr_dest), .o_rx_accept(acc),
    .o_rx_drop(drop), .o_fec_active(fec), .o_repeater_en(rep), .o_csma_en(csma));

  peer_modem_model peer_modem_model_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_slow(slow), .i_send(send), .i_send_dest(sdest),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_rdy), .i_tx_dest(tx_dest),
    .o_hdr_valid(hdr_v), .o_hdr_dest(hdr_dest), .o_nbytes(nbytes),
    .o_last_byte(last_b), .o_frame_dest(f_dest), .o_delivered(dlv));

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic conclude;
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic timed_out;
    fail_count++;
    conclude();
  endtask

  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) timed_out();
    wb_q = o_wb_dat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic host_send(input logic [7:0] b);
    int n;
    @(posedge clk);
    hv <= 1'b1; hd <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (host_rdy !== 1'b1 && n < 400);
    if (n >= 400) timed_out();
    hv <= 1'b0;
  endtask

  // Header through the peer, then wait for the verdict pulse
  task automatic rx_hdr(input logic [7:0] d, input logic e);
    int n;
    @(posedge clk);
    send <= 1'b1; sdest <= d;
    @(posedge clk);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((acc | drop) !== 1'b1 && n < 5);
    if (n >= 5) timed_out();
    chk_bit(acc, e);
    chk_bit(drop, ~e);
  endtask

  // Bounded wait until the peer has counted the given number of bytes
  task automatic wait_bytes(input logic [7:0] k);
    int n;
    n = 0;
    while (nbytes !== k && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) timed_out();
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped read
    wb(1'b0, REG_DEST_ADDR, 32'h0); chk_word(wb_q, 32'h0000_00FF);
    wb(1'b0, REG_OWN_ADDR, 32'h0);  chk_word(wb_q, 32'h0000_0000);
    wb(1'b0, 8'hFC, 32'h0);         chk_word(wb_q, 32'h0000_0000);
    chk_bit(csma, 1'b1);
    chk_bit(rep, 1'b0);
    // Table of filter cases
    foreach (rows[i]) begin
      wb(1'b1, REG_OWN_ADDR, {16'h0, rows[i].own});
      wb(1'b1, REG_CTRL, {30'h0, rows[i].rxen, 1'b0});
      rx_hdr(rows[i].dest, rows[i].acc);
    end
    // Five accepted and one dropped header so far
    wb(1'b0, REG_COUNT, 32'h0); chk_word(wb_q, 32'h0001_0005);
    // Repeater commands
    wb(1'b1, REG_CMD, {24'h0, CMD_REPEATER_ON});  repeat (4) @(posedge clk);
    chk_bit(rep, 1'b1);
    wb(1'b0, REG_STATUS, 32'h0); chk_word(wb_q, 32'h0000_0015);
    wb(1'b1, REG_CMD, {24'h0, CMD_REPEATER_OFF}); repeat (4) @(posedge clk);
    chk_bit(rep, 1'b0);
    // Priority turns carrier sensing off
    wb(1'b1, REG_CTRL, 32'h0000_0008); repeat (4) @(posedge clk);
    chk_bit(csma, 1'b0);
    // Option 3 with FEC on: addressing off, FEC suspended then restored
    wb(1'b1, REG_OWN_ADDR, 32'h0000_0005);
    wb(1'b1, REG_CTRL, 32'h0000_0007); repeat (4) @(posedge clk);
    chk_bit(fec, 1'b1);
    wb(1'b1, REG_CMD, {24'h0, CMD_COMPAT_OPT3}); repeat (4) @(posedge clk);
    chk_bit(fec, 1'b0);
    chk_word({24'h0, tx_dest}, 32'h0000_00FF);
    wb(1'b0, REG_CTRL, 32'h0); chk_word(wb_q & 32'h3, 32'h0);
    rx_hdr(8'h55, 1'b1);
    wb(1'b1, REG_CTRL, 32'h0000_0004); repeat (4) @(posedge clk);
    chk_bit(fec, 1'b1);
    // Delay clamps at its maximum
    wb(1'b1, REG_TX_DELAY, 32'h0000_FFFF);
    wb(1'b0, REG_TX_DELAY, 32'h0); chk_word(wb_q, {16'h0, TX_DELAY_MAX});
    // Labelled frame through a stalling peer
    wb(1'b1, REG_TX_DELAY, 32'h0000_0001);
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    wb(1'b1, REG_DEST_ADDR, 32'h0000_0312);
    slow <= 1'b1;
    base = nbytes;
    host_send(8'hA1); host_send(8'hB2); host_send(8'hC3);
    wait_bytes(8'(base + 8'h03));
    chk_word({24'h0, last_b}, 32'h0000_00C3);
    chk_word({24'h0, f_dest}, 32'h0000_0012);
    chk_bit(dlv, 1'b0);
    // Second frame labelled with the peer's own address is delivered
    wb(1'b1, REG_DEST_ADDR, 32'h0000_0000);
    host_send(8'h5A);
    wait_bytes(8'(base + 8'h04));
    chk_word({24'h0, last_b}, 32'h0000_005A);
    chk_bit(dlv, 1'b1);
    // Mid-run reset restores defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, REG_DEST_ADDR, 32'h0); chk_word(wb_q, 32'h0000_00FF);
    chk_bit(fec, 1'b0);
    conclude();
  end

  // Overall run limit
  initial begin
    repeat (50000) @(posedge clk);
    timed_out();
  end
endmodule
`default_nettype wire
